// ---- rtl/bus_wait_pkg.sv ----
/*
 Package for the internal bus wait and hold control block.
 Holds register offsets, bit positions, reset values, area bounds and types.
 Assumes a 32-bit APB slave port with byte addresses.
*/
package bus_wait_pkg;

    // Printed offsets are not all multiples of four: they are indices
    localparam logic [11:0] MODE_CTRL_IDX   = 12'h005;
    localparam logic [11:0] AREA2_CTRL_IDX  = 12'h010;
    localparam logic [11:0] FLASH_CTRL1_IDX = 12'h221;
    localparam logic [11:0] PROTECT_IDX     = 12'h00A;
    localparam logic [11:0] FLASH_CTRL0_IDX = 12'h220;
    localparam logic [11:0] CSPROT_IDX      = 12'h01F;
    localparam logic [11:0] STATUS_IDX      = 12'h030;

    localparam logic [7:0] MODE_CTRL_RST   = 8'h08;
    localparam logic [7:0] AREA2_CTRL_RST  = 8'h00;
    localparam logic [7:0] FLASH_CTRL1_RST = 8'h00;

    localparam int DAE_BIT   = 0;
    localparam int STICKY_BIT = 2;
    localparam int IMW_BIT   = 7;
    localparam int P2D_BIT   = 0;
    localparam int DAW_BIT   = 7;
    localparam int MRPE_BIT  = 1;
    localparam int A2PE_BIT  = 6;
    localparam int CFRE_BIT  = 1;
    localparam int CSP_BIT   = 7;

    localparam logic [19:0] DATA_LO  = 20'h0E000;
    localparam logic [19:0] DATA_HI  = 20'h0FFFF;
    localparam logic [19:0] BLKA_HI  = 20'h0EFFF;
    localparam logic [19:0] BLKB_LO  = 20'h0F000;
    localparam logic [19:0] PROM2_LO = 20'h10000;
    localparam logic [19:0] PROM2_HI = 20'h13FFF;
    localparam logic [19:0] SFR_HI   = 20'h003FF;
    localparam logic [19:0] RAM_HI   = 20'h07FFF;

    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;

    typedef enum logic [1:0] {
        AREA_SFR,
        AREA_RAM,
        AREA_ROM,
        AREA_DATA
    } area_t;

    typedef enum logic [1:0] {
        OWN_CPU,
        OWN_DMA,
        OWN_HOLD
    } owner_t;

    // One requester's access request
    typedef struct packed {
        logic        req;
        logic [19:0] addr;
        logic        write;
        logic        oddWordFirst;
    } busReq_t;

endpackage : bus_wait_pkg

// ---- rtl/internal_bus_wait_hold.sv ----
/*
 Internal bus wait-state selection and ownership arbiter.
 Assumes an APB master on the register port, requests synchronous to clk,
 and requesters that hold their request until they see their done pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module internal_bus_wait_hold
    import bus_wait_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Requesters
    input  wire busReq_t     cpuReq,
    input  wire busReq_t     dmaReq,
    output var  logic        cpuDone,
    output var  logic        dmaDone,
    output var  logic        cpuStall,
    output var  logic        dmaStall,
    // Flash and system status
    input  wire logic        ew1AutoBusy,
    output var  logic        busHold,
    output var  logic        portFreeze,
    output var  logic        wdtStop,
    output var  logic        dataAreaSel,
    output var  logic        prom2Disable,
    output var  logic        illegalAccess
);

    typedef struct packed {
        logic [7:0]  modeCtrl;
        logic [7:0]  area2Ctrl;
        logic [7:0]  flashCtrl1;
        logic [7:0]  protect;
        logic [7:0]  flashCtrl0;
        logic [7:0]  csProt;
        owner_t      owner;
        logic [1:0]  cycLeft;
        logic        busy;
        logic        lockCpu;
        logic [31:0] rdata;
        logic        ready;
        logic        slvErr;
        logic        cpuDone;
        logic        dmaDone;
        logic        hold;
        logic        wdtStop;
        logic        illegal;
        logic        cpuStall;
        logic        dmaStall;
        logic        busHold;
        logic        dataSel;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    function automatic area_t areaOf(input logic [19:0] a);
        if (a <= SFR_HI)
            areaOf = AREA_SFR;
        else if (a >= DATA_LO && a <= DATA_HI)
            areaOf = AREA_DATA;
        else if (a <= RAM_HI)
            areaOf = AREA_RAM;
        else
            areaOf = AREA_ROM;
    endfunction : areaOf

    // Bus cycle length in clocks for one access
    function automatic logic [1:0] cycLen(input busReq_t r, input logic imw,
                                          input logic daw);
        case (areaOf(r.addr))
            AREA_SFR:  cycLen = CYC_TWO;
            AREA_RAM,
            AREA_ROM:  cycLen = imw ? CYC_TWO : CYC_ONE;
            AREA_DATA: cycLen = (imw || (!daw && !r.write)) ? CYC_TWO : CYC_ONE;
            default:   cycLen = CYC_TWO;
        endcase
    endfunction : cycLen

    logic        rewriteOn;
    logic        daeEff;
    logic [11:0] regIdx;
    logic        apbAcc;
    logic        wrAcc;

    assign rewriteOn = st_r.flashCtrl0[CFRE_BIT];
    assign daeEff    = st_r.modeCtrl[DAE_BIT] | rewriteOn;
    assign regIdx    = paddr[13:2];
    assign apbAcc    = psel & penable & st_r.ready;
    assign wrAcc     = apbAcc & pwrite;

    always_comb begin
        st_nxt = st_r;
        st_nxt.cpuDone = 1'b0;
        st_nxt.dmaDone = 1'b0;
        st_nxt.illegal = 1'b0;
        // APB: setup cycle raises ready, access completes next edge
        st_nxt.ready  = psel & ~penable;
        st_nxt.slvErr = 1'b0;
        if (psel && !penable) begin
            st_nxt.slvErr = 1'b0;
            st_nxt.rdata  = 32'h0000_0000;
            case (regIdx)
                MODE_CTRL_IDX:   st_nxt.rdata[7:0] = {st_r.modeCtrl[7:1], daeEff};
                AREA2_CTRL_IDX:  st_nxt.rdata[7:0] = st_r.area2Ctrl;
                FLASH_CTRL1_IDX: st_nxt.rdata[7:0] = st_r.flashCtrl1;
                PROTECT_IDX:     st_nxt.rdata[7:0] = st_r.protect;
                FLASH_CTRL0_IDX: st_nxt.rdata[7:0] = st_r.flashCtrl0;
                CSPROT_IDX:      st_nxt.rdata[7:0] = st_r.csProt;
                STATUS_IDX:      st_nxt.rdata[7:0] = {4'h0, st_r.lockCpu, st_r.hold,
                                                      st_r.owner};
                default:         st_nxt.slvErr = 1'b1;
            endcase
        end
        if (wrAcc) begin
            case (regIdx)
                MODE_CTRL_IDX:
                    if (st_r.protect[MRPE_BIT]) begin
                        st_nxt.modeCtrl = pwdata[7:0];
                        st_nxt.modeCtrl[STICKY_BIT] = st_r.modeCtrl[STICKY_BIT]
                                                    | pwdata[STICKY_BIT];
                    end
                AREA2_CTRL_IDX:
                    if (st_r.protect[A2PE_BIT])
                        st_nxt.area2Ctrl = {7'h00, pwdata[P2D_BIT]};
                FLASH_CTRL1_IDX: st_nxt.flashCtrl1 = {pwdata[DAW_BIT], 7'h00};
                PROTECT_IDX:     st_nxt.protect    = pwdata[7:0];
                FLASH_CTRL0_IDX: st_nxt.flashCtrl0 = pwdata[7:0];
                CSPROT_IDX:      st_nxt.csProt     = pwdata[7:0];
                default:         st_nxt.illegal    = 1'b0;
            endcase
        end
        // Bus hold and its side effects
        st_nxt.hold    = ew1AutoBusy;
        st_nxt.wdtStop = ew1AutoBusy & ~st_r.csProt[CSP_BIT];
        // Ownership and bus cycle timing
        if (st_r.busy && st_r.cycLeft > CYC_ONE) begin
            st_nxt.cycLeft = st_r.cycLeft - CYC_ONE;
        end else begin
            if (st_r.busy) begin
                st_nxt.cpuDone = (st_r.owner == OWN_CPU);
                st_nxt.dmaDone = (st_r.owner == OWN_DMA);
                st_nxt.busy    = 1'b0;
            end
            // Boundary: re-arbitrate; a request still standing under its done pulse is stale
            if (ew1AutoBusy) begin
                st_nxt.owner = OWN_HOLD;
                st_nxt.busy  = 1'b0;
            end else if (dmaReq.req && !st_r.lockCpu && !st_r.dmaDone
                         && !(st_r.busy && st_r.owner == OWN_DMA)) begin
                st_nxt.owner   = OWN_DMA;
                st_nxt.busy    = 1'b1;
                st_nxt.cycLeft = cycLen(dmaReq, st_r.modeCtrl[IMW_BIT],
                                        st_r.flashCtrl1[DAW_BIT]);
            end else if (cpuReq.req && !st_r.cpuDone
                         && !(st_r.busy && st_r.owner == OWN_CPU)) begin
                st_nxt.owner   = OWN_CPU;
                st_nxt.busy    = 1'b1;
                st_nxt.lockCpu = cpuReq.oddWordFirst;
                st_nxt.cycLeft = cycLen(cpuReq, st_r.modeCtrl[IMW_BIT],
                                        st_r.flashCtrl1[DAW_BIT]);
                // Data area or area 2 touched while unmapped
                if ((areaOf(cpuReq.addr) == AREA_DATA && !daeEff)
                    || (cpuReq.addr >= PROM2_LO && cpuReq.addr <= PROM2_HI
                        && st_r.area2Ctrl[P2D_BIT]))
                    st_nxt.illegal = 1'b1;
            end else begin
                st_nxt.owner = OWN_CPU;
            end
        end
        // Output flops follow the owner and mode bits with no extra delay
        st_nxt.cpuStall = st_nxt.owner != OWN_CPU;
        st_nxt.dmaStall = st_nxt.owner != OWN_DMA;
        st_nxt.busHold  = st_nxt.owner == OWN_HOLD;
        st_nxt.dataSel  = st_nxt.modeCtrl[DAE_BIT] | st_nxt.flashCtrl0[CFRE_BIT];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r            <= '0;
            st_r.modeCtrl   <= MODE_CTRL_RST;
            st_r.area2Ctrl  <= AREA2_CTRL_RST;
            st_r.flashCtrl1 <= FLASH_CTRL1_RST;
            st_r.owner      <= OWN_CPU;
            st_r.dmaStall   <= 1'b1;
            st_r.dataSel    <= MODE_CTRL_RST[DAE_BIT];
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata        = st_r.rdata;
    assign pready        = st_r.ready;
    assign pslverr       = st_r.slvErr;
    assign cpuDone       = st_r.cpuDone;
    assign dmaDone       = st_r.dmaDone;
    assign cpuStall      = st_r.cpuStall;
    assign dmaStall      = st_r.dmaStall;
    assign busHold       = st_r.busHold;
    assign portFreeze    = st_r.hold;
    assign wdtStop       = st_r.wdtStop;
    assign dataAreaSel   = st_r.dataSel;
    assign prom2Disable  = st_r.area2Ctrl[P2D_BIT];
    assign illegalAccess = st_r.illegal;

    // Sticky bit never falls once set
    sticky_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(st_r.modeCtrl[STICKY_BIT]) |-> st_r.modeCtrl[STICKY_BIT])
        else $error("sticky mode bit cleared");

    mode_protect_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wrAcc && regIdx == MODE_CTRL_IDX && !st_r.protect[MRPE_BIT])
        |=> $stable(st_r.modeCtrl))
        else $error("mode register changed while protected");

    area2_protect_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wrAcc && regIdx == AREA2_CTRL_IDX && !st_r.protect[A2PE_BIT])
        |=> $stable(st_r.area2Ctrl))
        else $error("area-2 register changed while protected");

    dae_force_a: assert property (@(posedge clk) disable iff (!rst_n)
        rewriteOn |-> dataAreaSel)
        else $error("data area not forced during rewrite");

    hold_grant_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ew1AutoBusy && !(st_r.busy && st_r.cycLeft > CYC_ONE)) |=> busHold)
        else $error("hold not granted");

    hold_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
        busHold |-> (cpuStall && dmaStall))
        else $error("requester running during hold");

    wdt_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        ew1AutoBusy |=> (wdtStop == !$past(st_r.csProt[CSP_BIT])))
        else $error("watchdog stop wrong during hold");

    odd_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.lockCpu && st_r.owner == OWN_CPU) |=> (st_r.owner != OWN_DMA))
        else $error("dma granted inside odd word access");

    sfr_two_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!st_r.busy && !ew1AutoBusy && !dmaReq.req && cpuReq.req && !st_r.cpuDone
         && cpuReq.addr <= SFR_HI) |=> (st_r.cycLeft == CYC_TWO))
        else $error("register area cycle not two clocks");

    dma_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!st_r.busy && !ew1AutoBusy && dmaReq.req && !st_r.lockCpu && !st_r.dmaDone)
        |=> (st_r.owner == OWN_DMA))
        else $error("dma lost to cpu");

endmodule : internal_bus_wait_hold
`default_nettype wire

// ---- verif/bus_requester.sv ----
/*
 Behavioural requester standing for the processor core or the DMA controller.
 Assumes one-cycle done pulses from the arbiter, sampled at the rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module bus_requester
    import bus_wait_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Bench side
    input  wire logic        go,
    input  wire logic [19:0] goAddr,
    input  wire logic        goWrite,
    input  wire logic        goOdd,
    // Arbiter side
    input  wire logic        done,
    output var  busReq_t     req
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req <= '0;
        end else if (go) begin
            req <= '{1'b1, goAddr, goWrite, goOdd};
        end else if (done && req.oddWordFirst) begin
            // Second half of an odd-address word follows at once
            req <= '{1'b1, req.addr + 20'h00001, req.write, 1'b0};
        end else if (done) begin
            // Released lines show a changed value, not the last one
            req <= '{1'b0, ~req.addr, ~req.write, 1'b0};
        end
    end
endmodule : bus_requester
`default_nettype wire

// ---- verif/internal_bus_wait_hold_bench.sv ----
/*
 Self-checking bench: register access over APB, wait states, priority, hold.
 Assumes the arbiter timing and register indices of the design package.
*/
`timescale 1ns/100ps
`default_nettype none
module internal_bus_wait_hold_bench;
    import bus_wait_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, cpuDone, dmaDone;
    logic cpuStall, dmaStall, ew1AutoBusy, busHold, portFreeze, wdtStop;
    logic dataAreaSel, prom2Disable, illegalAccess, cGo, cWr, cOdd, dGo;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [19:0] cAddr, dAddr;
    busReq_t     cpuReq, dmaReq;
    logic [32:0] rdQ[$];
    int          latQ[$];
    logic        doneLog[$];
    int          fails = 0, n_checks = 0, lat = 0, nIll = 0;
    logic [7:0]  tm[10] = '{8'h0D, 8'h0D, 8'h0D, 8'h0D, 8'h0D, 8'h0D, 8'h8D, 8'h8D, 8'h8D, 8'h8D};
    logic [7:0]  tf[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80};
    logic [19:0] ta[10] = '{20'h00100, 20'h0, 20'h20000, 20'h0E000, 20'h0F000, 20'h0EFFF,
                            20'h0, 20'h20000, 20'h0F000, 20'h00100};
    logic        tw[10] = '{0, 0, 0, 0, 1, 0, 0, 0, 0, 0};
    int          tc[10] = '{2, 1, 1, 2, 1, 1, 2, 2, 2, 2};

    internal_bus_wait_hold internal_bus_wait_hold_i (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpuReq(cpuReq), .dmaReq(dmaReq),
        .cpuDone(cpuDone), .dmaDone(dmaDone), .cpuStall(cpuStall), .dmaStall(dmaStall),
        .ew1AutoBusy(ew1AutoBusy), .busHold(busHold), .portFreeze(portFreeze),
        .wdtStop(wdtStop), .dataAreaSel(dataAreaSel), .prom2Disable(prom2Disable),
        .illegalAccess(illegalAccess));
    bus_requester cpu_requester_i (.clk(clk), .rst_n(rst_n), .go(cGo), .goAddr(cAddr),
        .goWrite(cWr), .goOdd(cOdd), .done(cpuDone), .req(cpuReq));
    bus_requester dma_requester_i (.clk(clk), .rst_n(rst_n), .go(dGo), .goAddr(dAddr),
        .goWrite(cWr), .goOdd(cOdd), .done(dmaDone), .req(dmaReq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [32:0] e, input logic [32:0] s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, e, s);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 14'({idx, 2'b00});
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++t < 50);
        if (t >= 50) fails++;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle cycle: the write has settled before anyone looks at it
        @(posedge clk);
    endtask : apb

    task automatic rd(input logic [11:0] idx, input logic [32:0] e);
        rdQ.push_back(e);
        apb(1'b0, idx, 8'h00);
    endtask : rd

    task automatic wreg(input logic [11:0] idx, input logic [7:0] d, input logic [7:0] p);
        apb(1'b1, PROTECT_IDX, p);
        apb(1'b1, idx, d);
    endtask : wreg

    task automatic waitLog(input int n);
        int t;
        t = 0;
        while (doneLog.size() < n && t++ < 200) @(posedge clk);
        if (t >= 200) fails++;
    endtask : waitLog

    task automatic go(input logic c, input logic d, input logic [19:0] a, input logic odd);
        cGo <= c;
        dGo <= d;
        cAddr <= a;
        dAddr <= 20'h00400 + 20'($urandom % 32'h7000);
        cOdd <= odd;
        @(posedge clk);
        cGo <= 1'b0;
        dGo <= 1'b0;
        @(posedge clk);
    endtask : go

    // Monitor: read data and access latency against the oldest notes
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rdQ.size() > 0)
            check("prdata", rdQ.pop_front(), {pslverr, prdata});
        if (cpuReq.req) lat = lat + 1;
        if (cpuDone === 1'b1) begin
            if (latQ.size() > 0 && latQ[0] != 0) check("latency", 33'(latQ[0]), 33'(lat));
            if (latQ.size() > 0) void'(latQ.pop_front());
            doneLog.push_back(1'b1);
            lat = 0;
        end
        if (dmaDone === 1'b1) doneLog.push_back(1'b0);
        if (illegalAccess === 1'b1) nIll++;
    end

    initial begin
        #200us;
        fails++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, cGo, cWr, cOdd, dGo, cAddr, dAddr} = '0;
        ew1AutoBusy = 1'b0;
        void'($urandom(4));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(MODE_CTRL_IDX, {1'b0, 24'h0, MODE_CTRL_RST});
        rd(AREA2_CTRL_IDX, 33'h0);
        rd(12'h3FF, {1'b1, 32'h0});
        wreg(MODE_CTRL_IDX, 8'hFF, 8'h00);
        rd(MODE_CTRL_IDX, 33'h08);
        wreg(MODE_CTRL_IDX, 8'h0D, 8'h02);
        wreg(MODE_CTRL_IDX, 8'h09, 8'h02);
        rd(MODE_CTRL_IDX, 33'h0D);
        check("dataAreaSel", 33'h1, 33'(dataAreaSel));
        wreg(AREA2_CTRL_IDX, 8'h01, 8'h00);
        rd(AREA2_CTRL_IDX, 33'h0);
        wreg(AREA2_CTRL_IDX, 8'h01, 8'h40);
        check("prom2Disable", 33'h1, 33'(prom2Disable));
        for (int i = 0; i < 10; i++) begin
            wreg(MODE_CTRL_IDX, tm[i], 8'h02);
            apb(1'b1, FLASH_CTRL1_IDX, tf[i]);
            doneLog.delete();
            latQ.push_back(tc[i] + 2);
            cWr <= tw[i];
            go(1'b1, 1'b0, ta[i] != 0 ? ta[i] : 20'h00400 + 20'($urandom % 32'h7000), 1'b0);
            waitLog(1);
        end
        wreg(MODE_CTRL_IDX, 8'h0C, 8'h02);
        check("dataAreaSel", 33'h0, 33'(dataAreaSel));
        doneLog.delete();
        latQ.push_back(0);
        go(1'b1, 1'b0, 20'h0E800, 1'b0);
        waitLog(1);
        check("illegal", 33'h1, 33'(nIll));
        doneLog.delete();
        latQ.push_back(0);
        go(1'b1, 1'b0, 20'h12000, 1'b0);
        waitLog(1);
        check("illegal", 33'h2, 33'(nIll));
        apb(1'b1, FLASH_CTRL0_IDX, 8'h02);
        rd(MODE_CTRL_IDX, 33'h0D);
        apb(1'b1, FLASH_CTRL0_IDX, 8'h00);
        cWr <= 1'b0;
        doneLog.delete();
        latQ.push_back(0);
        go(1'b1, 1'b1, 20'h00600, 1'b0);
        waitLog(2);
        check("order", 33'h1, 33'({doneLog[0], doneLog[1]}));
        doneLog.delete();
        latQ.push_back(3);
        latQ.push_back(3);
        go(1'b1, 1'b0, 20'h00401, 1'b1);
        go(1'b0, 1'b1, 20'h00401, 1'b0);
        waitLog(3);
        check("order", 33'h6, 33'({doneLog[0], doneLog[1], doneLog[2]}));
        apb(1'b1, CSPROT_IDX, 8'h80);
        doneLog.delete();
        ew1AutoBusy <= 1'b1;
        repeat (3) @(posedge clk);
        latQ.push_back(0);
        go(1'b1, 1'b0, 20'h00700, 1'b0);
        repeat (5) @(posedge clk);
        check("holdFlags", 33'h1E, 33'({busHold, cpuStall, dmaStall, portFreeze, wdtStop}));
        check("doneInHold", 33'h0, 33'(doneLog.size()));
        apb(1'b1, CSPROT_IDX, 8'h00);
        repeat (2) @(posedge clk);
        check("wdtStop", 33'h1, 33'(wdtStop));
        ew1AutoBusy <= 1'b0;
        waitLog(1);
        check("afterHold", 33'h1, 33'(doneLog[0]));
        report_and_stop();
    end
endmodule : internal_bus_wait_hold_bench
`default_nettype wire
